// ---- hdl/cpu_instruction_semantics.v ----
// Purpose: executes one 14-bit instruction at a time against its own state
// Assumes: inputs synchronous to ref_clk, one clock per instruction cycle
// Notes: registers and data memory reached over AXI4-Lite
//
// Functional notes
// - relative jump: pc plus one plus acc
// - set one bit, flags untouched
// - call pushes pc+1, latch 6:3 upper
// - watchdog kick clears counters, sets both status
// - call via acc: latch bits form upper
// - invert register, zero flag updated
// - clear register or accumulator, zero set
// - increment or decrement, zero flag only
// - decrement then skip next when zero
// - increment then skip next when zero
// - absolute jump, latch 6:3 upper, no push
// - or with literal or register, zero
// - left shift, bit 7 to carry
// - right shift, bit 0 to carry
// - copy register, zero flag from value
// - four pointer update modes by code
// - indexed form: pointer plus signed offset
// - pointers wrap modulo sixteen bits
// - alias accesses location held by pointer
// - load bank and upper latch literals
// - load literal, one cycle; store acc, one cycle unless alias with pointer msb
// - alias with pointer msb adds cycle
// - pointer updates never touch status flags
`include "cpu_instruction_semantics_regs.vh"

module cpu_instruction_semantics #(
	parameter ADDR_W = 12,
	parameter PRESC_W = 8,
	parameter WDT_W = 8,
	parameter SP_W = 4
) (
	input wire ref_clk,
	input wire rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam ST_IDLE = 2'd0;
	localparam ST_EXEC = 2'd1;
	localparam ST_HOLD = 2'd2;

	reg [1:0] state_q;
	reg [13:0] ir_q;
	reg [1:0] wait_q;
	reg [1:0] cycles_q;
	reg [7:0] acc_q;
	reg c_q;
	reg z_q;
	reg sleep_status_n_q;
	reg expiry_status_n_q;
	reg [14:0] program_counter_q;
	reg [6:0] program_counter_upper_latch_q;
	reg [4:0] bank_select_q;
	reg [15:0] ptr0_q;
	reg [15:0] ptr1_q;
	reg [PRESC_W-1:0] presc_q;
	reg [WDT_W-1:0] watchdog_counter_q;
	reg [SP_W-1:0] sp_q;
	reg [14:0] stack_q [0:(1<<SP_W)-1];
	reg [7:0] mem_q [0:127];
	integer i;

	// execution results
	reg [7:0] ex_res;
	reg ex_wacc;
	reg ex_wmem;
	reg [6:0] ex_addr;
	reg [7:0] fval;
	reg ex_updz;
	reg ex_updc;
	reg ex_c;
	reg [14:0] ex_pc;
	reg ex_push;
	reg [1:0] ex_cyc;
	reg ex_slow;
	reg ex_pwe;
	reg ex_psel;
	reg [15:0] ex_pval;
	reg ex_bank_we;
	reg ex_latch_we;
	reg ex_kick;
	reg [15:0] pcur;
	reg [15:0] pn;
	reg [15:0] pinc;
	reg [15:0] pdec;
	reg [15:0] ea;
	wire [6:0] fsel = ir_q[6:0];
	wire alias_hit = (fsel[6:1] == 6'h00);
	wire [14:0] pc_inc = program_counter_q + 15'd1;

	always @* begin
		ex_res = 8'h00;
		ex_wacc = 1'b0;
		ex_wmem = 1'b0;
		ex_updz = 1'b0;
		ex_updc = 1'b0;
		ex_c = c_q;
		ex_pc = pc_inc;
		ex_push = 1'b0;
		ex_cyc = `CYC_ONE;
		ex_pwe = 1'b0;
		ex_psel = 1'b0;
		ex_pval = 16'h0000;
		ex_bank_we = 1'b0;
		ex_latch_we = 1'b0;
		ex_kick = 1'b0;
		// aliases hold nothing; the pointer names the location
		pcur = fsel[0] ? ptr1_q : ptr0_q;
		ex_addr = alias_hit ? pcur[6:0] : fsel;
		ex_slow = alias_hit & pcur[15];
		pn = ir_q[2] ? ptr1_q : ptr0_q;
		pinc = pn + 16'h0001;
		pdec = pn - 16'h0001;
		ea = pn;
		casez (ir_q)
			`OP_IND_RD, `OP_IND_WR: begin
				case (ir_q[1:0])
					2'b00: ea = pinc;
					2'b01: ea = pdec;
					default: ea = pn;
				endcase
				ex_pwe = 1'b1;
				ex_psel = ir_q[2];
				ex_pval = ir_q[0] ? pdec : pinc;
				ex_addr = ea[6:0];
				ex_slow = pn[15];
			end
			`OP_IDX_RD, `OP_IDX_WR: begin
				pn = ir_q[6] ? ptr1_q : ptr0_q;
				ea = pn + {{10{ir_q[5]}}, ir_q[5:0]};
				ex_addr = ea[6:0];
				ex_slow = pn[15];
			end
			default: begin
			end
		endcase
		fval = mem_q[ex_addr];
		casez (ir_q)
			`OP_NOP: begin
			end
			`OP_REL_JUMP_ACC: begin
				ex_pc = pc_inc + {7'h00, acc_q};
				ex_cyc = `CYC_TWO;
			end
			`OP_SUB_JUMP_ACC: begin
				ex_push = 1'b1;
				ex_pc = {program_counter_upper_latch_q, acc_q};
				ex_cyc = `CYC_TWO;
			end
			`OP_KICK: ex_kick = 1'b1;
			`OP_IND_RD, `OP_IDX_RD: begin
				ex_res = fval;
				ex_wacc = 1'b1;
				ex_updz = 1'b1;
			end
			`OP_IND_WR, `OP_IDX_WR: begin
				ex_res = acc_q;
				ex_wmem = 1'b1;
			end
			`OP_BANK: ex_bank_we = 1'b1;
			`OP_STORE: begin
				ex_res = acc_q;
				ex_wmem = 1'b1;
			end
			`OP_ZACC: begin
				ex_wacc = 1'b1;
				ex_updz = 1'b1;
				ex_slow = 1'b0;
			end
			`OP_ZREG: begin
				ex_wmem = 1'b1;
				ex_updz = 1'b1;
			end
			`OP_DEC, `OP_INC, `OP_DECSZ, `OP_INCSZ: begin
				// increment forms are 1010 and 1111
				ex_res = (ir_q[11] & (ir_q[10] | ~ir_q[8])) ?
					fval + 8'h01 : fval - 8'h01;
				ex_wacc = ~ir_q[7];
				ex_wmem = ir_q[7];
				ex_updz = ~(ir_q[11] & ir_q[8]);
				if (ir_q[11] && ir_q[8] && ex_res == 8'h00) begin
					ex_pc = program_counter_q + 15'd2;
					ex_cyc = `CYC_TWO;
				end
			end
			`OP_OR_REG, `OP_COPY, `OP_INV: begin
				case (ir_q[11:8])
					4'b0100: ex_res = acc_q | fval;
					4'b1000: ex_res = fval;
					default: ex_res = ~fval;
				endcase
				ex_wacc = ~ir_q[7];
				ex_wmem = ir_q[7];
				ex_updz = 1'b1;
			end
			`OP_BCLR, `OP_BSET: begin
				ex_res = fval;
				ex_res[ir_q[9:7]] = ir_q[10];
				ex_wmem = 1'b1;
			end
			`OP_CALL, `OP_JUMP: begin
				ex_push = ~ir_q[11];
				// upper bits from latch 6:3 for both forms
				ex_pc = {program_counter_upper_latch_q[6:3], ir_q[10:0]};
				ex_cyc = `CYC_TWO;
			end
			`OP_LIT_ACC: begin
				ex_res = ir_q[7:0];
				ex_wacc = 1'b1;
				ex_slow = 1'b0;
			end
			`OP_LATCH: ex_latch_we = 1'b1;
			`OP_SHL, `OP_SHR: begin
				ex_res = ir_q[8] ? {fval[6:0], 1'b0} : {1'b0, fval[7:1]};
				ex_c = ir_q[8] ? fval[7] : fval[0];
				ex_wacc = ~ir_q[7];
				ex_wmem = ir_q[7];
				ex_updz = 1'b1;
				ex_updc = 1'b1;
			end
			`OP_OR_LIT: begin
				ex_res = acc_q | ir_q[7:0];
				ex_wacc = 1'b1;
				ex_updz = 1'b1;
				ex_slow = 1'b0;
			end
			default: begin
			end
		endcase
		if (ex_slow && (ex_wacc || ex_wmem))
			ex_cyc = ex_cyc + 2'd1;
	end

	// register map read, shared by both channels
	function [32:0] rmap;
		input [ADDR_W-1:0] a;
		begin
			rmap = {1'b1, 32'h00000000};
			if (a[ADDR_W-1:9] == `MEM_BASE_HI)
				rmap[7:0] = mem_q[a[8:2]];
			else begin
				case (a)
					`OFS_INSTR: rmap[13:0] = ir_q;
					`OFS_ACC: rmap[7:0] = acc_q;
					`OFS_STATUS: begin
						rmap[`ST_C] = c_q;
						rmap[`ST_Z] = z_q;
						rmap[`ST_SLEEP_N] = sleep_status_n_q;
						rmap[`ST_EXPIRY_N] = expiry_status_n_q;
						rmap[`ST_BUSY] = (state_q != ST_IDLE);
					end
					`OFS_PC: rmap[14:0] = program_counter_q;
					`OFS_LATCH: rmap[6:0] = program_counter_upper_latch_q;
					`OFS_BANK: rmap[4:0] = bank_select_q;
					`OFS_PTR0: rmap[15:0] = ptr0_q;
					`OFS_PTR1: rmap[15:0] = ptr1_q;
					`OFS_WATCHDOG: rmap[WDT_W-1:0] = watchdog_counter_q;
					`OFS_SP: rmap[SP_W-1:0] = sp_q;
					`OFS_CYCLES: rmap[1:0] = cycles_q;
					default: rmap = {1'b0, 32'h00000000};
				endcase
			end
		end
	endfunction

	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
	wire [32:0] wr_old = rmap(s_axi_awaddr);
	wire [32:0] rd_val = rmap(s_axi_araddr);
	wire idle = (state_q == ST_IDLE);
	wire bus_we = wr_go & wr_old[32] & idle;
	reg [31:0] wv;
	always @* begin
		for (i = 0; i < 4; i = i + 1)
			wv[i*8 +: 8] = s_axi_wstrb[i] ? s_axi_wdata[i*8 +: 8]
				: wr_old[i*8 +: 8];
	end
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_old[32] ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val[31:0];
				s_axi_rresp <= rd_val[32] ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			ir_q <= `OP_NOP;
			wait_q <= 2'd0;
			cycles_q <= 2'd0;
			acc_q <= `RST_ACC;
			c_q <= 1'b0;
			z_q <= 1'b0;
			sleep_status_n_q <= 1'b1;
			expiry_status_n_q <= 1'b1;
			program_counter_q <= `RST_PC;
			program_counter_upper_latch_q <= `RST_LATCH;
			bank_select_q <= `RST_BANK;
			ptr0_q <= `RST_PTR;
			ptr1_q <= `RST_PTR;
			presc_q <= {PRESC_W{1'b0}};
			watchdog_counter_q <= {WDT_W{1'b0}};
			sp_q <= {SP_W{1'b0}};
			for (i = 0; i < (1<<SP_W); i = i + 1)
				stack_q[i] <= `RST_PC;
			for (i = 0; i < 128; i = i + 1)
				mem_q[i] <= `RST_BYTE;
		end else begin
			// free-running watchdog; expiry clears the active-low bit
			presc_q <= presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};
			if (&presc_q) begin
				watchdog_counter_q <= watchdog_counter_q +
					{{(WDT_W-1){1'b0}}, 1'b1};
				if (&watchdog_counter_q)
					expiry_status_n_q <= 1'b0;
			end
			case (state_q)
				ST_IDLE: begin
					if (bus_we) begin
						if (s_axi_awaddr[ADDR_W-1:9] == `MEM_BASE_HI)
							mem_q[s_axi_awaddr[8:2]] <= wv[7:0];
						else begin
							case (s_axi_awaddr)
								`OFS_INSTR: begin
									ir_q <= wv[13:0];
									state_q <= ST_EXEC;
								end
								`OFS_ACC: acc_q <= wv[7:0];
								`OFS_STATUS: begin
									c_q <= wv[`ST_C];
									z_q <= wv[`ST_Z];
								end
								`OFS_PC: program_counter_q <= wv[14:0];
								`OFS_LATCH:
									program_counter_upper_latch_q <= wv[6:0];
								`OFS_BANK: bank_select_q <= wv[4:0];
								`OFS_PTR0: ptr0_q <= wv[15:0];
								`OFS_PTR1: ptr1_q <= wv[15:0];
								default: begin
								end
							endcase
						end
					end
				end
				ST_EXEC: begin
					if (ex_wacc)
						acc_q <= ex_res;
					if (ex_wmem)
						mem_q[ex_addr] <= ex_res;
					if (ex_updz)
						z_q <= (ex_res == 8'h00);
					if (ex_updc)
						c_q <= ex_c;
					program_counter_q <= ex_pc;
					if (ex_push) begin
						stack_q[sp_q] <= pc_inc;
						sp_q <= sp_q + {{(SP_W-1){1'b0}}, 1'b1};
					end
					if (ex_pwe && !ex_psel)
						ptr0_q <= ex_pval;
					if (ex_pwe && ex_psel)
						ptr1_q <= ex_pval;
					if (ex_bank_we)
						bank_select_q <= ir_q[4:0];
					if (ex_latch_we)
						program_counter_upper_latch_q <= ir_q[6:0];
					if (ex_kick) begin
						presc_q <= {PRESC_W{1'b0}};
						watchdog_counter_q <= {WDT_W{1'b0}};
						expiry_status_n_q <= 1'b1;
						sleep_status_n_q <= 1'b1;
					end
					cycles_q <= ex_cyc;
					wait_q <= ex_cyc - 2'd1;
					state_q <= (ex_cyc == `CYC_ONE) ? ST_IDLE : ST_HOLD;
				end
				ST_HOLD: begin
					wait_q <= wait_q - 2'd1;
					if (wait_q == 2'd1)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule // cpu_instruction_semantics

// ---- hdl/cpu_instruction_semantics_regs.vh ----
// Purpose: offsets, fields, reset values and opcode patterns of the core
// Assumes: 32-bit register bus, one aligned word per register
// Notes: opcode patterns are 14-bit casez masks
`ifndef CPU_INSTRUCTION_SEMANTICS_REGS_VH
`define CPU_INSTRUCTION_SEMANTICS_REGS_VH

// register byte offsets
`define OFS_INSTR 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_PC 12'h00c
`define OFS_LATCH 12'h010
`define OFS_BANK 12'h014
`define OFS_PTR0 12'h018
`define OFS_PTR1 12'h01c
`define OFS_WATCHDOG 12'h020
`define OFS_SP 12'h024
`define OFS_CYCLES 12'h028
`define MEM_BASE_HI 3'h1

// status fields
`define ST_C 0
`define ST_Z 1
`define ST_SLEEP_N 3
`define ST_EXPIRY_N 4
`define ST_BUSY 8

// reset values
`define RST_ACC 8'h00
`define RST_PC 15'h0000
`define RST_LATCH 7'h00
`define RST_BANK 5'h00
`define RST_PTR 16'h0000
`define RST_BYTE 8'h00

// instruction cycle counts
`define CYC_ONE 2'd1
`define CYC_TWO 2'd2

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// opcode patterns
`define OP_NOP 14'b00_0000_0000_0000
`define OP_SUB_JUMP_ACC 14'b00_0000_0000_1010
`define OP_REL_JUMP_ACC 14'b00_0000_0000_1011
`define OP_KICK 14'b00_0000_0110_0100
`define OP_IND_RD 14'b00_0000_0001_0???
`define OP_IND_WR 14'b00_0000_0001_1???
`define OP_BANK 14'b00_0000_001?_????
`define OP_STORE 14'b00_0000_1???_????
`define OP_ZACC 14'b00_0001_0???_????
`define OP_ZREG 14'b00_0001_1???_????
`define OP_DEC 14'b00_0011_????_????
`define OP_OR_REG 14'b00_0100_????_????
`define OP_COPY 14'b00_1000_????_????
`define OP_INV 14'b00_1001_????_????
`define OP_INC 14'b00_1010_????_????
`define OP_DECSZ 14'b00_1011_????_????
`define OP_INCSZ 14'b00_1111_????_????
`define OP_BCLR 14'b01_00??_????_????
`define OP_BSET 14'b01_01??_????_????
`define OP_CALL 14'b10_0???_????_????
`define OP_JUMP 14'b10_1???_????_????
`define OP_LIT_ACC 14'b11_0000_????_????
`define OP_LATCH 14'b11_0001_1???_????
`define OP_SHL 14'b11_0101_????_????
`define OP_SHR 14'b11_0110_????_????
`define OP_OR_LIT 14'b11_1000_????_????
`define OP_IDX_RD 14'b11_1111_0???_????
`define OP_IDX_WR 14'b11_1111_1???_????

`endif

// ---- tb/cpu_instruction_semantics_monitor.sv ----
// Purpose: handshake checks on the core's register port
// Assumes: one clock, reset active high
// Notes: sees the top module's ports only
module cpu_instruction_semantics_monitor #(parameter ADDR_W = 12) (
	input wire ref_clk,
	input wire rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("write not answered next cycle");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response not released");
	a_ready_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("address and data ready differ");
	a_no_wr_pending: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken with response pending");
	a_no_rd_pending: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken with response pending");
	a_b_cause: assert property ($rose(s_axi_bvalid)
		|-> $past(s_axi_awvalid && s_axi_awready))
		else $error("write response without request");
	a_rresp_legal: assert property (s_axi_rvalid
		|-> s_axi_rresp inside {2'b00, 2'b10})
		else $error("illegal read response code");
endmodule // cpu_instruction_semantics_monitor
bind cpu_instruction_semantics cpu_instruction_semantics_monitor
	#(.ADDR_W(ADDR_W)) u_mon (.*);

// ---- tb/tb.sv ----
// Purpose: random instruction stream checked against a bench model
// Assumes: register map and opcode patterns of the design header
// Notes: run is far shorter than a watchdog expiry
`include "cpu_instruction_semantics_regs.vh"
`define CHK(n,e,s) begin samples_checked++; if ((s)!==(e)) begin \
	mismatches++; $display("Error %s exp %0h got %0h", n, e, s); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int mismatches = 0, samples_checked = 0, seed = 1700, n_cyc = 0;
	int acc, c, z, pc, lat, bnk, sp, cy, e, x, ps, i;
	int p[2];
	int m[128];
	logic [31:0] v, o;
	logic [1:0] rr;
	logic [31:0] tab[27] = '{32'h000b0000, 32'h000a0000, 32'h00640000,
		32'h00100007, 32'h00180007, 32'h0020001f, 32'h0080007f,
		32'h01000000, 32'h0180007f, 32'h030000ff, 32'h040000ff,
		32'h080000ff, 32'h090000ff, 32'h0a0000ff, 32'h0b0000ff,
		32'h0f0000ff, 32'h100003ff, 32'h140003ff, 32'h200007ff,
		32'h280007ff, 32'h300000ff, 32'h3180007f, 32'h350000ff,
		32'h360000ff, 32'h380000ff, 32'h3f00007f, 32'h3f80007f};
	logic [11:0] ad[10] = '{`OFS_ACC, `OFS_STATUS, `OFS_PC, `OFS_CYCLES,
		`OFS_LATCH, `OFS_BANK, `OFS_PTR0, `OFS_PTR1, `OFS_SP, 0};
	string nm[10] = '{"acc", "status", "pc", "cycles", "latch", "bank",
		"ptr0", "ptr1", "sp", "mem"};

	cpu_instruction_semantics i_dut (.*);

	initial forever #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		n_cyc++;
		if (n_cyc > 40000) begin
			mismatches++;
			end_of_test();
		end
	end

	task end_of_test;
		$display("checked %0d mismatched %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task wr(input [11:0] a, input [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do @(posedge ref_clk); while (s_axi_awready !== 1);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1);
		s_axi_bready <= 0;
	endtask

	task rd(input [11:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge ref_clk); while (s_axi_arready !== 1);
		s_axi_arvalid <= 0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1);
		v = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// file address 0/1 reach memory through a pointer
	function int fa(int f);
		return f < 2 ? p[f] & 127 : f;
	endfunction

	task put(int r, int d);
		if (d) m[e] = r;
		else acc = r;
		cy += x;
	endtask

	task mv(int w);
		if (w) put(acc, 1);
		else begin
			put(m[e], 0);
			z = acc == 0;
		end
	endtask

	task step(int n, int dn);
		p[n] = (p[n] + (dn ? -1 : 1)) & 65535;
	endtask

	task model(input [13:0] o);
		int r, n, k;
		e = fa(o[6:0]);
		x = o[6:0] < 2 ? p[o[0]] >> 15 & 1 : 0;
		r = m[e];
		cy = 1;
		pc = (pc + 1) & 32767;
		casez (o)
			`OP_REL_JUMP_ACC: begin pc = (pc + acc) & 32767; cy = 2; end
			`OP_SUB_JUMP_ACC: begin
				pc = lat << 8 | acc;
				cy = 2;
				sp = (sp + 1) & 15;
			end
			`OP_IND_RD, `OP_IND_WR: begin
				n = o[2];
				x = p[n] >> 15;
				if (o[1:0] < 2) step(n, o[0]);
				e = p[n] & 127;
				mv(o[3]);
				if (o[1:0] > 1) step(n, o[0]);
			end
			`OP_BANK: bnk = o[4:0];
			`OP_STORE: put(acc, 1);
			`OP_ZACC: begin acc = 0; z = 1; end
			`OP_ZREG: begin put(0, 1); z = 1; end
			`OP_DEC: begin put((r - 1) & 255, o[7]); z = r == 1; end
			`OP_OR_REG: begin put(r | acc, o[7]); z = (r | acc) == 0; end
			`OP_COPY: begin put(r, o[7]); z = r == 0; end
			`OP_INV: begin put(~r & 255, o[7]); z = r == 255; end
			`OP_INC: begin put((r + 1) & 255, o[7]); z = r == 255; end
			`OP_DECSZ: begin
				put((r - 1) & 255, o[7]);
				if (r == 1) begin pc = (pc + 1) & 32767; cy++; end
			end
			`OP_INCSZ: begin
				put((r + 1) & 255, o[7]);
				if (r == 255) begin pc = (pc + 1) & 32767; cy++; end
			end
			`OP_BCLR: put(r & ~(1 << o[9:7]), 1);
			`OP_BSET: put(r | 1 << o[9:7], 1);
			`OP_CALL, `OP_JUMP: begin
				pc = (lat >> 3) << 11 | o[10:0];
				cy = 2;
				if (!o[11]) sp = (sp + 1) & 15;
			end
			`OP_LIT_ACC: acc = o[7:0];
			`OP_LATCH: lat = o[6:0];
			`OP_SHL: begin put(r << 1 & 255, o[7]); c = r >> 7; z = (r & 127) == 0; end
			`OP_SHR: begin put(r >> 1, o[7]); c = r & 1; z = r < 2; end
			`OP_OR_LIT: begin acc |= o[7:0]; z = acc == 0; end
			`OP_IDX_RD, `OP_IDX_WR: begin
				k = (p[o[6]] + $signed(o[5:0])) & 65535;
				e = k & 127;
				x = p[o[6]] >> 15;
				mv(o[7]);
			end
			default: ;
		endcase
	endtask

	task cmp;
		int q[10];
		q = '{acc, c | z << 1 | 24, pc, cy, lat, bnk, p[0], p[1], sp, m[e]};
		for (int j = 0; j < 10; j++) begin
			rd(j < 9 ? ad[j] : 12'h200 + e * 4);
			`CHK(nm[j], q[j], v & (j == 1 ? 32'h1b : 32'hffffffff))
		end
	endtask

	task ex(input [13:0] o);
		model(o);
		wr(`OFS_INSTR, {18'h0, o});
		do rd(`OFS_STATUS); while (v[`ST_BUSY] !== 1'b0);
		if (o == `OP_KICK) begin
			rd(`OFS_WATCHDOG);
			`CHK("watchdog", 0, v)
		end
		cmp();
	endtask

	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 0;
		e = 2;
		cmp();
		for (i = 0; i < 128; i++) begin
			m[i] = $random(seed) & 255;
			wr(12'h200 + i * 4, m[i]);
		end
		rd(12'h100);
		`CHK("unmapped", {2'b10, 32'h0}, {rr, v})
		for (ps = 0; ps < 8; ps++) begin
			p[0] = $random(seed) & 65535;
			p[1] = $random(seed) & 65535;
			wr(`OFS_PTR0, p[0]);
			wr(`OFS_PTR1, p[1]);
			for (i = 0; i < 27; i++) begin
				o = tab[i][31:16] | ($random(seed) & tab[i][15:0]);
				// odd passes force the skip case
				if (ps % 2 && (i == 14 || i == 15)) begin
					e = fa(o[6:0]);
					m[e] = i == 14 ? 1 : 255;
					wr(12'h200 + e * 4, m[e]);
				end
				ex(o[13:0]);
			end
			$display("pass %0d done", ps);
		end
		wr(`OFS_CYCLES, 32'h7);
		rd(`OFS_CYCLES);
		`CHK("cycles ro", cy, v)
		end_of_test();
	end
endmodule // tb
